/* t1pm_error_counters.sv */
// Performance error counters of one T1 framer with their host registers
// Operation
// - Refresh counts each one-second tick, or every 42 ms when interval_select set.
// - At each boundary the finished interval's count moves into readable registers.
// - Counters stop at their maximum and never wrap.
// - Line violation count is 16 bits, high byte at 23h, low at 24h.
// - Count bipolar violations plus 16- or 8-zero runs; substitution words never.
// - Line violation counter keeps counting during loss of sync.
// - In extended superframe the path counter counts CRC6 errors, 12 bits.
// - In superframe count Ft errors, plus Fs errors when enabled.
// - Path counter counts nothing while sync is lost.
// - Path bits 11..8 in low nibble of 25h, bits 7..0 at 26h.
// - Out-of-sync bits 11..8 in high nibble of 25h, bits 7..0 at 27h.
// - Mode 1 counts out-of-sync multiframes, only during loss of sync.
// - Mode 0 counts Ft or FPS pattern errors, halted during loss of sync.
// - Mask register two enables each of eight events with a one bit.
// - One-second ticks are spaced 999, 999 and 1002 ms, repeating.
// - Loss of sync is true whenever the framer is not synchronized.
`timescale 1ns/100ps
module t1pm_error_counters
  import t1pm_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wr_data,
  input wire logic bus_rd,
  input wire logic bus_wr,
  output logic [7:0] rd_data,
  input wire logic interval_select,
  input wire logic zero_substitution_enable,
  input wire logic extended_superframe_select,
  input wire logic count_zero_runs_enable,
  input wire logic count_fs_errors_enable,
  input wire logic oos_count_mode_select,
  input wire logic rx_sync_lost,
  input wire logic bpv_event,
  input wire logic substitution_word_event,
  input wire logic zero_run16_event,
  input wire logic zero_run8_event,
  input wire logic crc6_error_event,
  input wire logic ft_error_event,
  input wire logic fs_error_event,
  input wire logic fps_error_event,
  input wire logic rx_multiframe_event,
  input wire logic [7:0] status_two,
  output logic one_second_tick,
  output logic update_strobe,
  output logic irq_n
);

  localparam int MS_W = $clog2(MS_CYCLES_P + 1);
  localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES_P - 1);
  localparam logic [9:0] SEC_SHORT_LAST = 10'(SEC_SHORT_MS - 1);
  localparam logic [9:0] SEC_LONG_LAST = 10'(SEC_LONG_MS - 1);
  localparam logic [5:0] FAST_LAST = 6'(FAST_INTERVAL_MS - 1);

  // ------------------------------------------------------------
  // Interval timer
  // ------------------------------------------------------------
  logic [MS_W-1:0] ms_cnt_r;
  logic [MS_W-1:0] ms_cnt_nxt;
  logic [9:0] sec_ms_r;
  logic [9:0] sec_ms_nxt;
  logic [5:0] fast_ms_r;
  logic [5:0] fast_ms_nxt;
  t1pm_phase_e phase_r;
  t1pm_phase_e phase_nxt;
  logic sec_tick_r;
  logic sec_tick_nxt;
  logic update_r;
  logic update_nxt;
  logic ms_tick;
  logic fast_tick;
  logic sec_tick;
  logic [9:0] sec_last;

  // Millisecond prescaler, then the 999/999/1002 ms pattern and the 42 ms interval
  always_comb begin
    ms_tick = (ms_cnt_r == MS_LAST);
    ms_cnt_nxt = ms_tick ? '0 : ms_cnt_r + MS_W'(1);
    case (phase_r)
      sec_third: sec_last = SEC_LONG_LAST;
      default: sec_last = SEC_SHORT_LAST;
    endcase
    sec_tick = ms_tick && (sec_ms_r == sec_last);
    fast_tick = ms_tick && (fast_ms_r == FAST_LAST);
    sec_ms_nxt = sec_ms_r;
    fast_ms_nxt = fast_ms_r;
    phase_nxt = phase_r;
    if (ms_tick) begin
      sec_ms_nxt = sec_tick ? '0 : sec_ms_r + 10'd1;
      fast_ms_nxt = fast_tick ? '0 : fast_ms_r + 6'd1;
    end
    if (sec_tick) begin
      case (phase_r)
        sec_first: phase_nxt = sec_second;
        sec_second: phase_nxt = sec_third;
        default: phase_nxt = sec_first;
      endcase
    end
    sec_tick_nxt = sec_tick;
    update_nxt = interval_select ? fast_tick : sec_tick;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ms_cnt_r <= '0;
      sec_ms_r <= '0;
      fast_ms_r <= '0;
      phase_r <= sec_first;
      sec_tick_r <= 1'b0;
      update_r <= 1'b0;
    end else begin
      ms_cnt_r <= ms_cnt_nxt;
      sec_ms_r <= sec_ms_nxt;
      fast_ms_r <= fast_ms_nxt;
      phase_r <= phase_nxt;
      sec_tick_r <= sec_tick_nxt;
      update_r <= update_nxt;
    end
  end

  // ------------------------------------------------------------
  // Event qualification
  // ------------------------------------------------------------
  t1pm_cnt_if #(.W(LCV_WIDTH)) lcv_if (.ref_clk(ref_clk), .rst_n(rst_n));
  t1pm_cnt_if #(.W(PCV_WIDTH)) pcv_if (.ref_clk(ref_clk), .rst_n(rst_n));
  t1pm_cnt_if #(.W(MOS_WIDTH)) mos_if (.ref_clk(ref_clk), .rst_n(rst_n));

  logic bpv_counted;
  logic zero_run_counted;

  // Line violations ignore sync state; path counts stop while sync is lost
  always_comb begin
    bpv_counted = bpv_event && !(zero_substitution_enable && substitution_word_event);
    zero_run_counted = count_zero_runs_enable &&
      (zero_substitution_enable ? zero_run8_event : zero_run16_event);
    lcv_if.inc = bpv_counted || zero_run_counted;
    pcv_if.inc = !rx_sync_lost && (extended_superframe_select ? crc6_error_event :
      (ft_error_event || (count_fs_errors_enable && fs_error_event)));
    if (oos_count_mode_select) begin
      mos_if.inc = rx_multiframe_event && rx_sync_lost;
    end else begin
      mos_if.inc = !rx_sync_lost &&
        (extended_superframe_select ? fps_error_event : ft_error_event);
    end
    lcv_if.latch = update_r;
    pcv_if.latch = update_r;
    mos_if.latch = update_r;
  end

  t1pm_sat_counter #(.WIDTH(LCV_WIDTH)) u_line_violation_counter (.cif(lcv_if));
  t1pm_sat_counter #(.WIDTH(PCV_WIDTH)) u_path_violation_counter (.cif(pcv_if));
  t1pm_sat_counter #(.WIDTH(MOS_WIDTH)) u_out_of_sync_counter (.cif(mos_if));

  // ------------------------------------------------------------
  // Host registers and interrupt
  // ------------------------------------------------------------
  logic [7:0] mask_two_r;
  logic [7:0] mask_two_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic irq_n_r;
  logic irq_n_nxt;

  // Read decode returns the held counts; only the mask is writable
  always_comb begin
    mask_two_nxt = mask_two_r;
    if (bus_wr && (bus_addr == ADDR_MASK_TWO)) begin
      mask_two_nxt = bus_wr_data;
    end
    rd_data_nxt = rd_data_r;
    if (bus_rd) begin
      if (bus_addr == ADDR_LCV_HIGH) begin
        rd_data_nxt = lcv_if.held[15:8];
      end else if (bus_addr == ADDR_LCV_LOW) begin
        rd_data_nxt = lcv_if.held[7:0];
      end else if (bus_addr == ADDR_SHARED_HIGH) begin
        rd_data_nxt = {mos_if.held[11:8], pcv_if.held[11:8]};
      end else if (bus_addr == ADDR_PCV_LOW) begin
        rd_data_nxt = pcv_if.held[7:0];
      end else if (bus_addr == ADDR_MOS_LOW) begin
        rd_data_nxt = mos_if.held[7:0];
      end else if (bus_addr == ADDR_MASK_TWO) begin
        rd_data_nxt = mask_two_r;
      end else begin
        rd_data_nxt = UNMAPPED_READ;
      end
    end
    irq_n_nxt = ~|(status_two & mask_two_r);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mask_two_r <= MASK_TWO_RESET;
      rd_data_r <= UNMAPPED_READ;
      irq_n_r <= 1'b1;
    end else begin
      mask_two_r <= mask_two_nxt;
      rd_data_r <= rd_data_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data = rd_data_r;
  assign one_second_tick = sec_tick_r;
  assign update_strobe = update_r;
  assign irq_n = irq_n_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  update_source_a: assert property (
    (interval_select ? fast_tick : sec_tick) |=> update_r && lcv_if.latch)
    else $error("update boundary not taken from the selected timer");

  long_second_a: assert property (
    sec_tick && (phase_r == sec_third) |-> sec_ms_r == SEC_LONG_LAST ##1 phase_r == sec_first)
    else $error("third second of the pattern has the wrong length");

  line_read_a: assert property (
    bus_rd && (bus_addr == ADDR_LCV_HIGH) |=> rd_data == $past(lcv_if.held[15:8]))
    else $error("line count high byte read wrong");

  shared_read_a: assert property (
    bus_rd && (bus_addr == ADDR_SHARED_HIGH) |=>
      rd_data == {$past(mos_if.held[11:8]), $past(pcv_if.held[11:8])})
    else $error("shared nibble register read wrong");

  mask_write_a: assert property (
    bus_wr && (bus_addr == ADDR_MASK_TWO) ##1 !bus_wr[*2] |-> mask_two_r == $past(bus_wr_data, 2))
    else $error("mask register two lost its written value");

  irq_follows_a: assert property (
    |(status_two & mask_two_r) |=> !irq_n)
    else $error("unmasked event did not raise the interrupt");

  path_gate_a: assert property (
    rx_sync_lost |-> !pcv_if.inc)
    else $error("path counter counted during loss of sync");

  line_ungated_a: assert property (
    bpv_event && !(zero_substitution_enable && substitution_word_event) |-> lcv_if.inc)
    else $error("line violation dropped");

  oos_mode_a: assert property (
    oos_count_mode_select && rx_sync_lost && rx_multiframe_event |-> mos_if.inc)
    else $error("out-of-sync multiframe not counted");

  fbit_halt_a: assert property (
    !oos_count_mode_select && rx_sync_lost |-> !mos_if.inc)
    else $error("framing error counted during loss of sync");

  line_low_read_a: assert property (
    bus_rd && (bus_addr == ADDR_LCV_LOW) |=> rd_data == $past(lcv_if.held[7:0]))
    else $error("line count low byte read wrong");

  path_low_read_a: assert property (
    bus_rd && (bus_addr == ADDR_PCV_LOW) |=> rd_data == $past(pcv_if.held[7:0]))
    else $error("path count low byte read wrong");

  oos_low_read_a: assert property (
    bus_rd && (bus_addr == ADDR_MOS_LOW) |=> rd_data == $past(mos_if.held[7:0]))
    else $error("out-of-sync count low byte read wrong");

  mask_read_a: assert property (
    bus_rd && (bus_addr == ADDR_MASK_TWO) |=> rd_data == $past(mask_two_r))
    else $error("mask register two read back wrong");

  read_hold_a: assert property (
    !bus_rd |=> $stable(rd_data))
    else $error("read data changed without a read");

  irq_quiet_a: assert property (
    !(|(status_two & mask_two_r)) |=> irq_n)
    else $error("interrupt raised with every event masked");

  zero_run16_a: assert property (
    count_zero_runs_enable && !zero_substitution_enable && zero_run16_event |-> lcv_if.inc)
    else $error("run of sixteen zeros not counted");

  zero_run8_a: assert property (
    count_zero_runs_enable && zero_substitution_enable && zero_run8_event |-> lcv_if.inc)
    else $error("run of eight zeros not counted");

  sub_word_a: assert property (
    zero_substitution_enable && substitution_word_event &&
      !(count_zero_runs_enable && zero_run8_event) |-> !lcv_if.inc)
    else $error("substitution word counted as a violation");

  crc_count_a: assert property (
    extended_superframe_select && !rx_sync_lost && crc6_error_event |-> pcv_if.inc)
    else $error("CRC6 error not counted");

  fbit_count_a: assert property (
    !extended_superframe_select && !rx_sync_lost &&
      (ft_error_event || (count_fs_errors_enable && fs_error_event)) |-> pcv_if.inc)
    else $error("framing bit error not counted");

  fast_update_c: cover property (interval_select && update_r);
  second_update_c: cover property (!interval_select && update_r && phase_r == sec_first);
  irq_c: cover property (!irq_n && bus_rd && bus_addr == ADDR_MASK_TWO);

endmodule : t1pm_error_counters

/* t1pm_pkg.sv */
// Package holding offsets, widths, reset values and timing counts of the error counter block
package t1pm_pkg;

  // ------------------------------------------------------------
  // Register offsets on the parallel port
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_LCV_HIGH = 8'h23;
  localparam logic [7:0] ADDR_LCV_LOW = 8'h24;
  localparam logic [7:0] ADDR_SHARED_HIGH = 8'h25;
  localparam logic [7:0] ADDR_PCV_LOW = 8'h26;
  localparam logic [7:0] ADDR_MOS_LOW = 8'h27;
  localparam logic [7:0] ADDR_MASK_TWO = 8'h6F;

  // ------------------------------------------------------------
  // Field widths and reset values
  // ------------------------------------------------------------
  localparam int LCV_WIDTH = 16;
  localparam int PCV_WIDTH = 12;
  localparam int MOS_WIDTH = 12;
  localparam logic [7:0] MASK_TWO_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ------------------------------------------------------------
  // Timing: the clock, one millisecond and the update intervals
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SEC_SHORT_MS = 999;
  localparam int SEC_LONG_MS = 1002;
  localparam int FAST_INTERVAL_MS = 42;

  // Phase within the three-second pattern of the one-second timer
  typedef enum logic [1:0] {sec_first, sec_second, sec_third} t1pm_phase_e;

endpackage : t1pm_pkg

/* t1pm_cnt_if.sv */
// Interface between the error counter block and one saturating counter
`timescale 1ns/100ps
interface t1pm_cnt_if #(parameter int W = 16) (input wire logic ref_clk, input wire logic rst_n);
  logic inc;
  logic latch;
  logic [W-1:0] held;
  logic [W-1:0] acc;

  modport ctr (input ref_clk, input rst_n, input inc, input latch, output held, output acc);
  modport user (output inc, output latch, input held, input acc);
endinterface : t1pm_cnt_if

/* t1pm_sat_counter.sv */
// Saturating interval counter with a held copy of the last finished interval
`timescale 1ns/100ps
module t1pm_sat_counter
  import t1pm_pkg::*;
#(
  parameter int WIDTH = 16
) (
  t1pm_cnt_if.ctr cif
);

  localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] acc_r;
  logic [WIDTH-1:0] acc_nxt;
  logic [WIDTH-1:0] held_r;
  logic [WIDTH-1:0] held_nxt;

  // ------------------------------------------------------------
  // Accumulate and hand over at the boundary
  // ------------------------------------------------------------
  // An event in the boundary cycle belongs to the new interval
  always_comb begin
    held_nxt = held_r;
    acc_nxt = acc_r;
    if (cif.latch) begin
      held_nxt = acc_r;
      acc_nxt = cif.inc ? ONE : '0;
    end else if (cif.inc && (acc_r != MAX_COUNT)) begin
      acc_nxt = acc_r + ONE;
    end
  end

  always_ff @(posedge cif.ref_clk) begin
    if (!cif.rst_n) begin
      acc_r <= '0;
      held_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      held_r <= held_nxt;
    end
  end

  assign cif.held = held_r;
  assign cif.acc = acc_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge cif.ref_clk); endclocking
  default disable iff (!cif.rst_n);

  counter_saturates_a: assert property (
    (acc_r == MAX_COUNT) && !cif.latch |=> acc_r == MAX_COUNT)
    else $error("counter left its maximum inside an interval");

  boundary_handover_a: assert property (
    cif.latch |=> (held_r == $past(acc_r)) && (acc_r == ($past(cif.inc) ? ONE : '0)))
    else $error("boundary did not hand the interval count over");

  counter_steps_a: assert property (
    cif.inc && !cif.latch && (acc_r != MAX_COUNT) |=> acc_r == $past(acc_r) + ONE)
    else $error("counter missed an event");

  saturate_c: cover property (cif.inc && (acc_r == MAX_COUNT));

endmodule : t1pm_sat_counter

/* t1pm_framer_model.sv */
// Behavioural receive framer that issues error event pulses and the sync lost level
`timescale 1ns/100ps
module t1pm_framer_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [8:0] sel,
  input wire logic lose,
  output logic [8:0] events,
  output logic rx_sync_lost
);
  // ------------------------------------------------------------
  // Event pulses
  // ------------------------------------------------------------
  // One pulse per cycle on every selected line while fire is held
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      events <= 9'h000;
      rx_sync_lost <= 1'b0;
    end else begin
      events <= fire ? sel : 9'h000;
      rx_sync_lost <= lose;
    end
  end
endmodule : t1pm_framer_model

/* testbench.sv */
// Self-checking testbench of the error counter block
`timescale 1ns/100ps
module testbench;
  import t1pm_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int M = 8;
  localparam logic [8:0] BPV = 9'h001, SUB = 9'h002, Z16 = 9'h004, Z8 = 9'h008;
  localparam logic [8:0] CRC = 9'h010, FT = 9'h020, FS = 9'h040, FPS = 9'h080, RX_MULTIFRAME_EVENT = 9'h100;
  logic ref_clk = 1'b0, rst_n = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0, fire = 1'b0, lose = 1'b0;
  logic [7:0] bus_addr = 8'h00, bus_wr_data = 8'h00, status_two = 8'h00, rd_data;
  logic ivs = 1'b1, zsub = 1'b0, esf = 1'b0, zre = 1'b0, fse = 1'b0, oosm = 1'b0;
  logic [8:0] sel = 9'h000, ev;
  logic sync_lost, tick, upd, irq_n;
  int bad_count = 0, checks_done = 0;
  int cyc = 0, last_ev = 0;
  // Clock of 8 ns
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // Free cycle count for measuring event spacing
  always @(posedge ref_clk) cyc <= cyc + 1;
  t1pm_framer_model u_t1pm_framer_model (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire),
    .sel(sel), .lose(lose), .events(ev), .rx_sync_lost(sync_lost));
  t1pm_error_counters #(.MS_CYCLES_P(M)) u_t1pm_error_counters (.ref_clk(ref_clk),
    .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr_data(bus_wr_data), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .rd_data(rd_data), .interval_select(ivs),
    .zero_substitution_enable(zsub), .extended_superframe_select(esf),
    .count_zero_runs_enable(zre), .count_fs_errors_enable(fse),
    .oos_count_mode_select(oosm), .rx_sync_lost(sync_lost), .bpv_event(ev[0]),
    .substitution_word_event(ev[1]), .zero_run16_event(ev[2]), .zero_run8_event(ev[3]),
    .crc6_error_event(ev[4]), .ft_error_event(ev[5]), .fs_error_event(ev[6]),
    .fps_error_event(ev[7]), .rx_multiframe_event(ev[8]), .status_two(status_two),
    .one_second_tick(tick), .update_strobe(upd), .irq_n(irq_n));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task summarize;
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask : chk
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wr_data <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : wr
  // Waits for update strobe, or the second tick when sec is set; d is cycles since last event
  task wait_ev(input bit sec, output logic [15:0] d);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 10000) begin
        bad_count++;
        summarize();
      end
    end while ((sec ? tick : upd) !== 1'b1);
    d = 16'(cyc - last_ev);
    last_ev = cyc;
    if (sec) chk_bit(upd, 1'b1);
  endtask : wait_ev
  task fire_n(input logic [8:0] s, input int n, input logic l);
    @(posedge ref_clk);
    sel <= s;
    lose <= l;
    fire <= 1'b1;
    repeat (n) @(posedge ref_clk);
    fire <= 1'b0;
  endtask : fire_n
  // Reads all five count places after the next update and compares them
  task counts(input logic [15:0] l, input logic [11:0] p, input logic [11:0] o);
    logic [7:0] d;
    logic [15:0] t;
    wait_ev(1'b0, t);
    chk(t, 16'(42 * M));
    // The host reads right after the strobe, well inside the next interval
    rd(ADDR_LCV_HIGH, d);
    chk_byte(d, l[15:8]);
    rd(ADDR_LCV_LOW, d);
    chk_byte(d, l[7:0]);
    rd(ADDR_SHARED_HIGH, d);
    chk_byte(d, {o[11:8], p[11:8]});
    rd(ADDR_PCV_LOW, d);
    chk_byte(d, p[7:0]);
    rd(ADDR_MOS_LOW, d);
    chk_byte(d, o[7:0]);
  endtask : counts
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    logic [7:0] d;
    chk_bit(irq_n, 1'b1);
    rd(ADDR_MASK_TWO, d);
    chk_byte(d, MASK_TWO_RESET);
    wr(ADDR_LCV_HIGH, 8'hAA);
    rd(ADDR_LCV_HIGH, d);
    chk_byte(d, 8'h00);
    rd(8'h30, d);
    chk_byte(d, UNMAPPED_READ);
  endtask : t_reset
  // Saturation over one full second and the 999, 999, 1002 ms tick pattern
  task t_second;
    logic [7:0] d;
    logic [15:0] t;
    @(posedge ref_clk);
    ivs <= 1'b0;
    esf <= 1'b1;
    wait_ev(1'b1, t);
    fire_n(BPV | CRC | FPS, 4100, 1'b0);
    wait_ev(1'b1, t);
    chk(t, 16'(999 * M));
    rd(ADDR_LCV_HIGH, d);
    chk_byte(d, 8'h10);
    rd(ADDR_LCV_LOW, d);
    chk_byte(d, 8'h04);
    rd(ADDR_SHARED_HIGH, d);
    chk_byte(d, 8'hFF);
    rd(ADDR_PCV_LOW, d);
    chk_byte(d, 8'hFF);
    rd(ADDR_MOS_LOW, d);
    chk_byte(d, 8'hFF);
    wait_ev(1'b1, t);
    chk(t, 16'(1002 * M));
    wait_ev(1'b1, t);
    chk(t, 16'(999 * M));
  endtask : t_second
  // Superframe, plain line code, everything under loss of sync
  task t_lost;
    logic [15:0] t;
    @(posedge ref_clk);
    ivs <= 1'b1;
    esf <= 1'b0;
    zsub <= 1'b0;
    zre <= 1'b1;
    fse <= 1'b0;
    oosm <= 1'b0;
    wait_ev(1'b0, t);
    fire_n(BPV, 3, 1'b1);
    fire_n(Z16, 2, 1'b1);
    fire_n(Z8, 4, 1'b1);
    fire_n(FT, 4, 1'b1);
    counts(16'h0005, 12'h000, 12'h000);
  endtask : t_lost
  // Superframe with substitution and Fs counting while in sync
  task t_d4;
    logic [15:0] t;
    @(posedge ref_clk);
    zsub <= 1'b1;
    fse <= 1'b1;
    wait_ev(1'b0, t);
    fire_n(BPV | SUB, 2, 1'b0);
    fire_n(Z8, 3, 1'b0);
    fire_n(Z16, 2, 1'b0);
    fire_n(BPV, 1, 1'b0);
    fire_n(FT, 2, 1'b0);
    fire_n(FS, 3, 1'b0);
    fire_n(FPS, 1, 1'b0);
    counts(16'h0004, 12'h005, 12'h002);
  endtask : t_d4
  // Extended superframe counting CRC errors and multiframes out of sync
  task t_esf;
    logic [15:0] t;
    @(posedge ref_clk);
    esf <= 1'b1;
    oosm <= 1'b1;
    zre <= 1'b0;
    zsub <= 1'b0;
    wait_ev(1'b0, t);
    fire_n(CRC, 6, 1'b0);
    fire_n(FT, 2, 1'b0);
    fire_n(FPS, 1, 1'b0);
    fire_n(RX_MULTIFRAME_EVENT, 2, 1'b0);
    fire_n(RX_MULTIFRAME_EVENT, 3, 1'b1);
    fire_n(Z16, 1, 1'b1);
    fire_n(BPV, 2, 1'b1);
    counts(16'h0002, 12'h006, 12'h003);
    @(posedge ref_clk);
    lose <= 1'b0;
  endtask : t_esf
  // Each mask bit gates its own status bit onto the interrupt
  task t_mask;
    logic [7:0] d;
    for (int b = 0; b < 8; b++) begin
      @(posedge ref_clk);
      status_two <= 8'h01 << b;
      wr(ADDR_MASK_TWO, 8'h01 << b);
      repeat (2) @(posedge ref_clk);
      #1 chk_bit(irq_n, 1'b0);
      rd(ADDR_MASK_TWO, d);
      chk_byte(d, 8'h01 << b);
      wr(ADDR_MASK_TWO, ~(8'h01 << b));
      repeat (2) @(posedge ref_clk);
      #1 chk_bit(irq_n, 1'b1);
    end
  endtask : t_mask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 t_reset();
    t_second();
    t_lost();
    t_d4();
    t_esf();
    t_mask();
    summarize();
  end
endmodule : testbench
